// ### rtl/avc_pkg.sv
`default_nettype none
package avc_pkg;

   // Clock and self-clearing reset pulse timing.
   localparam int unsigned CLK_PERIOD_NS  = 25;
   localparam int unsigned RST_PULSE_NS   = 250;
   localparam int unsigned RST_PULSE_CYC_RAW =
      (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned RST_PULSE_CYC  = (RST_PULSE_CYC_RAW < 1) ? 1 : RST_PULSE_CYC_RAW;
   localparam int unsigned RST_CNT_W      = 4;
   localparam logic [3:0]  RST_PULSE_CNT  = 4'(RST_PULSE_CYC);

   // Register addresses in the controller address space.
   localparam logic [15:0] ADDR_TOP_CTRL  = 16'hA038;
   localparam logic [15:0] ADDR_C0_LEFT   = 16'hA1A0;
   localparam logic [15:0] ADDR_C0_RIGHT  = 16'hA1A1;
   localparam logic [15:0] ADDR_C1_LEFT   = 16'hA1A2;
   localparam logic [15:0] ADDR_C1_RIGHT  = 16'hA1A3;
   localparam logic [15:0] ADDR_MIX_LEFT  = 16'hA1A6;
   localparam logic [15:0] ADDR_MIX_RIGHT = 16'hA1A7;

   // Top control field positions.
   localparam int unsigned CTRL_RST_BIT   = 0;
   localparam int unsigned CTRL_EN_BIT    = 1;
   localparam int unsigned CTRL_DIG_BIT   = 2;
   localparam int unsigned CTRL_CLD_BIT   = 3;
   localparam logic [7:1]  CTRL_RST_VAL   = 7'h00;

   // Volume register layout.
   localparam int unsigned VOL_MUTE_BIT   = 7;
   localparam logic [7:0]  VOL_RST_VAL    = 8'h80;
   localparam int unsigned DAC_ATT_W      = 7;
   localparam int unsigned MIX_ATT_W      = 5;
   localparam int unsigned DAC_STEP_QDB   = 3;
   localparam int unsigned MIX_STEP_QDB   = 6;
   localparam int unsigned QDB_W          = 9;

   // Channel slots.
   localparam int unsigned NUM_CHAN       = 6;
   localparam logic [2:0]  SLOT_C0_LEFT   = 3'h0;
   localparam logic [2:0]  SLOT_C0_RIGHT  = 3'h1;
   localparam logic [2:0]  SLOT_C1_LEFT   = 3'h2;
   localparam logic [2:0]  SLOT_C1_RIGHT  = 3'h3;
   localparam logic [2:0]  SLOT_MIX_LEFT  = 3'h4;
   localparam logic [2:0]  SLOT_MIX_RIGHT = 3'h5;
   localparam logic [7:0]  RDATA_NONE     = 8'h00;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } avc_bus_req_t;

   typedef struct packed {
      logic subsys_rst;
      logic analog_standby;
      logic pll_run;
      logic dig_audio_pd;
      logic classd_pd;
   } avc_pwr_t;

   typedef struct packed {
      logic             silent;
      logic [QDB_W-1:0] atten_qdb;
   } avc_chan_t;

   // Returns {hit, slot} for a volume register address.
   function automatic logic [3:0] avc_vol_slot(input logic [15:0] addr);
      logic [3:0] res;
      res = 4'h0;
      unique case (addr)
         ADDR_C0_LEFT:   res = {1'b1, SLOT_C0_LEFT};
         ADDR_C0_RIGHT:  res = {1'b1, SLOT_C0_RIGHT};
         ADDR_C1_LEFT:   res = {1'b1, SLOT_C1_LEFT};
         ADDR_C1_RIGHT:  res = {1'b1, SLOT_C1_RIGHT};
         ADDR_MIX_LEFT:  res = {1'b1, SLOT_MIX_LEFT};
         ADDR_MIX_RIGHT: res = {1'b1, SLOT_MIX_RIGHT};
         default:        res = 4'h0;
      endcase
      return res;
   endfunction : avc_vol_slot

endpackage : avc_pkg
`default_nettype wire

// ### rtl/avc_regs_top.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Writing one to reset bit pulses subsystem reset; bit self-clears after 250 ns.
// - Enable bit low (default) holds analog in standby and the PLL stopped.
// - Digital sound path off bit at one powers down the digital audio path.
// - Amplifier digital path off bit at one powers down the Class-D logic.
// - Every register is eight bits and is written as one whole byte.
// - Bit 7 of each volume register is that channel's mute control.
// - Mute bit at one silences the channel; mute resets to one.
// - Converter attenuation is 7 bits, 0.75 dB per step, resets to zero.
// - Deepest converter attenuation is 95.25 dB at the top code.
// - Mixer attenuation is 5 bits, 1.5 dB per step; bits 6:5 reserved.
// - Mixer code 1Fh gives the maximum attenuation of 46.5 dB.
// - Each converter has separate left and right volume registers.
// - The mixer output has separate left and right volume registers.
module avc_regs_top
   import avc_pkg::*;
(
   input  wire logic                    clk_sys_i,
   input  wire logic                    sys_rst_i,
   input  wire avc_bus_req_t            bus_i,
   output var  logic [7:0]              rdata_o,
   output var  logic                    rvalid_o,
   output var  avc_pwr_t                pwr_o,
   output wire avc_chan_t [NUM_CHAN-1:0] chan_o
);

   logic [7:1] ctrl_ff;
   logic [7:0] vol_ff [NUM_CHAN];
   logic       rst_busy;
   logic       rst_start;
   logic       top_hit;
   logic [3:0] wr_slot;
   logic [3:0] rd_slot;
   logic       path_on;
   logic [7:0] nxt_rdata;

   assign top_hit   = (bus_i.addr == ADDR_TOP_CTRL);
   assign wr_slot   = avc_vol_slot(bus_i.addr);
   assign rd_slot   = avc_vol_slot(bus_i.addr);
   assign rst_start = bus_i.wr & top_hit & bus_i.wdata[CTRL_RST_BIT];

   // The reset bit itself lives in the pulse generator, never in ctrl_ff.
   avc_rst_pulse u_rst_pulse (
      .clk_sys_i (clk_sys_i),
      .sys_rst_i (sys_rst_i),
      .start_i   (rst_start),
      .busy_o    (rst_busy)
   );

   // Top control byte; bits 7:4 are reserved but keep what is written.
   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ctrl_ff <= CTRL_RST_VAL;
      end else if (bus_i.wr && top_hit) begin
         ctrl_ff <= bus_i.wdata[7:1];
      end
   end

   // Writes to unmapped or reserved addresses are dropped silently.
   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         for (int i = 0; i < NUM_CHAN; i++) begin
            vol_ff[i] <= VOL_RST_VAL;
         end
      end else if (bus_i.wr && wr_slot[3]) begin
         vol_ff[wr_slot[2:0]] <= bus_i.wdata;
      end
   end

   always_comb begin
      nxt_rdata = RDATA_NONE;
      if (top_hit) begin
         nxt_rdata = {ctrl_ff, rst_busy};
      end else if (rd_slot[3]) begin
         nxt_rdata = vol_ff[rd_slot[2:0]];
      end
   end

   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rdata_o  <= RDATA_NONE;
         rvalid_o <= 1'b0;
      end else begin
         rvalid_o <= bus_i.rd;
         if (bus_i.rd) begin
            rdata_o <= nxt_rdata;
         end
      end
   end

   // Power controls are registered so every output leaves from a flop.
   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pwr_o.subsys_rst     <= 1'b0;
         pwr_o.analog_standby <= 1'b1;
         pwr_o.pll_run        <= 1'b0;
         pwr_o.dig_audio_pd   <= 1'b0;
         pwr_o.classd_pd      <= 1'b0;
      end else begin
         pwr_o.subsys_rst     <= rst_busy;
         pwr_o.analog_standby <= ~ctrl_ff[CTRL_EN_BIT];
         pwr_o.pll_run        <= ctrl_ff[CTRL_EN_BIT];
         pwr_o.dig_audio_pd   <= ctrl_ff[CTRL_DIG_BIT];
         pwr_o.classd_pd      <= ctrl_ff[CTRL_CLD_BIT];
      end
   end

   // A channel cannot make sound while the audio path is disabled or in reset.
   assign path_on = ctrl_ff[CTRL_EN_BIT] & ~ctrl_ff[CTRL_DIG_BIT] & ~rst_busy;

   // The full 7-bit field is honoured, so code 7Fh reaches 95.25 dB.
   for (genvar g = 0; g < 4; g++) begin : g_dac
      avc_vol_chan #(
         .ATT_W    (DAC_ATT_W),
         .STEP_QDB (DAC_STEP_QDB)
      ) u_chan (
         .clk_sys_i (clk_sys_i),
         .sys_rst_i (sys_rst_i),
         .vol_i     (vol_ff[g]),
         .path_on_i (path_on),
         .chan_o    (chan_o[g])
      );
   end

   // Mixer bits 6:5 are stored but never reach the attenuation.
   for (genvar g = 4; g < NUM_CHAN; g++) begin : g_mix
      avc_vol_chan #(
         .ATT_W    (MIX_ATT_W),
         .STEP_QDB (MIX_STEP_QDB)
      ) u_chan (
         .clk_sys_i (clk_sys_i),
         .sys_rst_i (sys_rst_i),
         .vol_i     (vol_ff[g]),
         .path_on_i (path_on),
         .chan_o    (chan_o[g])
      );
   end

   // Helper: length of the current reset pulse, restarted by every start.
   logic [7:0] pulse_len_ff;
   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pulse_len_ff <= 8'h00;
      end else if (rst_start) begin
         pulse_len_ff <= 8'h01;
      end else if (rst_busy) begin
         pulse_len_ff <= pulse_len_ff + 8'h01;
      end
   end

   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (sys_rst_i);

   AST_RST_PULSE_LEN: assert property (
      $fell(rst_busy) |-> (pulse_len_ff == 8'(RST_PULSE_CYC + 1))
   ) else $error("Reset pulse length differs from the counted cycles.");

   // A start late in the pulse reloads the count, so ten quiet cycles are demanded first.
   AST_RST_SELF_CLEAR: assert property (
      (rst_start ##1 !rst_start [*8] ##1 !rst_start [*2]) |=> !rst_busy
   ) else $error("Reset bit did not clear by itself.");

   AST_RST_OUT: assert property (
      rst_start |=> ##1 pwr_o.subsys_rst
   ) else $error("Subsystem reset not driven after a reset write.");

   AST_EN_STANDBY: assert property (
      !ctrl_ff[CTRL_EN_BIT] |=> (pwr_o.analog_standby && !pwr_o.pll_run)
   ) else $error("Disabled audio not in standby.");

   AST_DIG_PD: assert property (
      ##1 (pwr_o.dig_audio_pd == $past(ctrl_ff[CTRL_DIG_BIT]))
   ) else $error("Digital audio power-down does not follow its bit.");

   AST_CLASSD_PD: assert property (
      (bus_i.wr && top_hit) |=> ##1 (pwr_o.classd_pd == $past(bus_i.wdata[CTRL_CLD_BIT], 2))
   ) else $error("Class-D power-down does not follow its bit.");

   AST_WR_BYTE: assert property (
      (bus_i.wr && wr_slot[3] && wr_slot[2:0] == SLOT_C0_LEFT)
         |=> (vol_ff[0] == $past(bus_i.wdata))
   ) else $error("Volume write did not store the whole byte.");

   AST_SEPARATE: assert property (
      (bus_i.wr && bus_i.addr == ADDR_C0_RIGHT) |=> $stable(vol_ff[0])
   ) else $error("Right write disturbed left volume.");

   AST_MIX_SEPARATE: assert property (
      (bus_i.wr && bus_i.addr == ADDR_MIX_LEFT) |=> $stable(vol_ff[5])
   ) else $error("Mixer left write disturbed right volume.");

   AST_MUTE_SILENT: assert property (
      vol_ff[2][VOL_MUTE_BIT] |=> chan_o[2].silent
   ) else $error("Muted converter channel is not silent.");

   AST_UNMUTE_SOUND: assert property (
      (!vol_ff[1][VOL_MUTE_BIT] && path_on) |=> !chan_o[1].silent
   ) else $error("Unmuted enabled channel is silent.");

   AST_DAC_ATT: assert property (
      ##1 (chan_o[3].atten_qdb == QDB_W'($past(vol_ff[3][6:0])) * QDB_W'(DAC_STEP_QDB))
   ) else $error("Converter attenuation step is wrong.");

   AST_DAC_MAX: assert property (
      (vol_ff[2][6:0] == 7'h7F) |=> (chan_o[2].atten_qdb == 9'h17D)
   ) else $error("Top converter code is not 95.25 dB.");

   AST_MIX_ATT: assert property (
      ##1 (chan_o[4].atten_qdb == QDB_W'($past(vol_ff[4][4:0])) * QDB_W'(MIX_STEP_QDB))
   ) else $error("Mixer attenuation step is wrong.");

   AST_MIX_MAX: assert property (
      (vol_ff[4][4:0] == 5'h1F) |=> (chan_o[4].atten_qdb == 9'h0BA)
   ) else $error("Top mixer code is not 46.5 dB.");

   AST_UNMAPPED_READ: assert property (
      (bus_i.rd && !top_hit && !rd_slot[3]) |=> (rvalid_o && rdata_o == RDATA_NONE)
   ) else $error("Unmapped read did not return zero.");

   COV_RST_PULSE: cover property (rst_start ##1 rst_busy [*8] ##1 rst_busy [*2] ##1 !rst_busy);
   COV_UNMUTE: cover property ($fell(chan_o[0].silent));
   COV_MIX_MAX: cover property (chan_o[4].atten_qdb == 9'h0BA);
   COV_READ_CTRL: cover property (bus_i.rd && top_hit ##1 rdata_o[CTRL_EN_BIT]);

endmodule : avc_regs_top
`default_nettype wire

// ### rtl/avc_rst_pulse.sv
`timescale 1ns/1ps
`default_nettype none
module avc_rst_pulse
   import avc_pkg::*;
(
   input  wire logic clk_sys_i,
   input  wire logic sys_rst_i,
   input  wire logic start_i,
   output var  logic busy_o
);

   logic [RST_CNT_W-1:0] cnt_ff;

   // A fresh start while busy reloads the count, so the pulse never ends early.
   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cnt_ff <= '0;
         busy_o <= 1'b0;
      end else if (start_i) begin
         cnt_ff <= RST_PULSE_CNT;
         busy_o <= 1'b1;
      end else if (cnt_ff != '0) begin
         cnt_ff <= cnt_ff - RST_CNT_W'(1);
         busy_o <= (cnt_ff != RST_CNT_W'(1));
      end
   end

endmodule : avc_rst_pulse
`default_nettype wire

// ### rtl/avc_vol_chan.sv
`timescale 1ns/1ps
`default_nettype none
module avc_vol_chan
   import avc_pkg::*;
#(
   parameter int unsigned ATT_W   = DAC_ATT_W,
   parameter int unsigned STEP_QDB = DAC_STEP_QDB
)(
   input  wire logic      clk_sys_i,
   input  wire logic      sys_rst_i,
   input  wire logic [7:0] vol_i,
   input  wire logic      path_on_i,
   output var avc_chan_t  chan_o
);

   logic [QDB_W-1:0] nxt_atten;

   // Attenuation is reported in quarter-dB units so both step sizes stay exact.
   always_comb begin
      nxt_atten = QDB_W'(vol_i[ATT_W-1:0]) * QDB_W'(STEP_QDB);
   end

   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         chan_o.silent    <= 1'b1;
         chan_o.atten_qdb <= '0;
      end else begin
         chan_o.silent    <= vol_i[VOL_MUTE_BIT] | ~path_on_i;
         chan_o.atten_qdb <= nxt_atten;
      end
   end

endmodule : avc_vol_chan
`default_nettype wire

// ### tb/avc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module avc_host_model
   import avc_pkg::*;
(
   input  wire logic       clk_sys_i,
   input  wire logic [7:0] rdata_i,
   input  wire logic       rvalid_i,
   output var  avc_bus_req_t bus_o
);
   initial begin
      bus_o = '0;
   end

   // One whole byte per access; callers also write reserved mixer bits 6:5 and read the unmapped address A000h.
   task automatic access(input logic w, input logic [15:0] a, input logic [7:0] d,
                         output logic [7:0] q);
      @(negedge clk_sys_i);
      bus_o = '{wr: w, rd: !w, addr: a, wdata: d};
      @(negedge clk_sys_i);
      q = (rvalid_i === 1'h1) ? rdata_i : 8'hXX;
      // Strobes drop low; address and data lines show the inverse of their last value, so stale data never matches.
      bus_o.wr    = 1'h0;
      bus_o.rd    = 1'h0;
      bus_o.addr  = ~bus_o.addr;
      bus_o.wdata = ~bus_o.wdata;
   endtask : access
endmodule : avc_host_model
`default_nettype wire

// ### tb/test_audio_volume_control_regs.sv
`timescale 1ns/1ps
`default_nettype none
module test_audio_volume_control_regs
   import avc_pkg::*;
;
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic [2:0]  slot;
      logic [8:0]  qdb;
   } avc_row_t;

   // Attenuation in quarter dB: 0.75 dB steps for converters, 1.5 dB for the mixer.
   localparam avc_row_t ROWS [6] = '{
      '{ADDR_C0_LEFT,   8'h00, SLOT_C0_LEFT,   9'h000},
      '{ADDR_C0_RIGHT,  8'h01, SLOT_C0_RIGHT,  9'h003},
      '{ADDR_C1_LEFT,   8'h7F, SLOT_C1_LEFT,   9'h17D},
      '{ADDR_C1_RIGHT,  8'h3F, SLOT_C1_RIGHT,  9'h0BD},
      '{ADDR_MIX_LEFT,  8'h1F, SLOT_MIX_LEFT,  9'h0BA},
      '{ADDR_MIX_RIGHT, 8'h61, SLOT_MIX_RIGHT, 9'h006}
   };

   logic                 clk_sys_i;
   logic                 sys_rst_i;
   avc_bus_req_t         bus;
   logic [7:0]           rdata;
   logic                 rvalid;
   avc_pwr_t             pwr;
   avc_chan_t [NUM_CHAN-1:0] chan;
   int                   mismatches;
   int                   total_checks;
   int                   n;

   avc_regs_top avc_regs_top_inst (
      .clk_sys_i (clk_sys_i),
      .sys_rst_i (sys_rst_i),
      .bus_i     (bus),
      .rdata_o   (rdata),
      .rvalid_o  (rvalid),
      .pwr_o     (pwr),
      .chan_o    (chan)
   );

   avc_host_model avc_host_model_inst (
      .clk_sys_i (clk_sys_i),
      .rdata_i   (rdata),
      .rvalid_i  (rvalid),
      .bus_o     (bus)
   );

   initial begin
      clk_sys_i = 1'h0;
   end
   always #12.5 clk_sys_i = ~clk_sys_i;

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : complete_run

   // Outputs that follow a write are settled one edge after the write edge.
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      logic [7:0] q;
      avc_host_model_inst.access(1'h1, a, d, q);
      @(negedge clk_sys_i);
   endtask : wr

   task automatic rd(input logic [15:0] a, output logic [7:0] q);
      avc_host_model_inst.access(1'h0, a, 8'h00, q);
   endtask : rd

   initial begin
      logic [7:0] q;
      mismatches   = 0;
      total_checks = 0;
      sys_rst_i    = 1'h1;
      repeat (20) @(negedge clk_sys_i);
      check(16'(pwr.analog_standby), 16'h1);
      check(16'(pwr.pll_run), 16'h0);
      sys_rst_i = 1'h0;
      rd(ADDR_TOP_CTRL, q);
      check(16'(q), 16'h00);
      for (int i = 0; i < 6; i++) begin
         rd(ROWS[i].addr, q);
         check(16'(q), 16'h80);
         check(16'(chan[ROWS[i].slot].silent), 16'h1);
      end
      wr(ADDR_TOP_CTRL, 8'h02);
      check(16'(pwr.pll_run), 16'h1);
      check(16'(pwr.analog_standby), 16'h0);
      for (int i = 0; i < 6; i++) begin
         wr(ROWS[i].addr, ROWS[i].wdata);
         rd(ROWS[i].addr, q);
         check(16'(q), 16'(ROWS[i].wdata));
         check(16'(chan[ROWS[i].slot].silent), 16'h0);
         check(16'(chan[ROWS[i].slot].atten_qdb), 16'(ROWS[i].qdb));
      end
      for (int i = 0; i < 6; i++) begin
         check(16'(chan[ROWS[i].slot].atten_qdb), 16'(ROWS[i].qdb));
      end
      wr(ADDR_C0_LEFT, 8'h85);
      check(16'(chan[0].silent), 16'h1);
      check(16'(chan[0].atten_qdb), 16'h00F);
      wr(ADDR_TOP_CTRL, 8'h06);
      check(16'(pwr.dig_audio_pd), 16'h1);
      check(16'(chan[1].silent), 16'h1);
      wr(ADDR_TOP_CTRL, 8'h0A);
      check(16'({pwr.classd_pd, pwr.dig_audio_pd}), 16'h2);
      check(16'(chan[1].silent), 16'h0);
      wr(ADDR_TOP_CTRL, 8'h00);
      check(16'({pwr.analog_standby, pwr.pll_run}), 16'h2);
      check(16'(chan[1].silent), 16'h1);
      rd(16'hA000, q);
      check(16'(q), 16'(RDATA_NONE));
      check(16'(rvalid), 16'h1);
      @(negedge clk_sys_i);
      check(16'(rvalid), 16'h0);
      // Reset pulse: count the cycles the subsystem reset stands high.
      wr(ADDR_TOP_CTRL, 8'h03);
      check(16'(chan[1].silent), 16'h1);
      n = 0;
      repeat (30) begin
         if (pwr.subsys_rst === 1'h1) begin
            n++;
         end
         @(negedge clk_sys_i);
      end
      check(16'(n), 16'(250 / 25));
      rd(ADDR_TOP_CTRL, q);
      check(16'(q), 16'h02);
      check(16'(chan[1].silent), 16'h0);
      sys_rst_i = 1'h1;
      repeat (2) @(negedge clk_sys_i);
      sys_rst_i = 1'h0;
      check(16'(pwr.analog_standby), 16'h1);
      check(16'(chan[1].silent), 16'h1);
      rd(ADDR_C1_LEFT, q);
      check(16'(q), 16'h80);
      complete_run();
   end

   initial begin
      #(25 * 5000);
      mismatches++;
      complete_run();
   end
endmodule : test_audio_volume_control_regs
`default_nettype wire
